// >>> logic/usb_fifo_pkg.sv
// Shared constants and carriers for the endpoint FIFO and clock recovery block.
// Assumes one 50 MHz system clock and byte-wide indirect register access.
`default_nettype none
package usb_fifo_pkg;
  // ----------------------------------------------------------------
  // Register addresses on the indirect bus
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_EP_PTR = 6'h0E; // Endpoint pointer register.
  localparam logic [5:0] ADDR_CLK_REC = 6'h0F; // Clock recovery control register.
  localparam logic [5:0] ADDR_FIFO0 = 6'h20; // First of four FIFO access ports.
  localparam logic [7:0] EP_PTR_RESET = 8'h00; // Endpoint pointer reset value.
  localparam logic [7:0] CLK_REC_RESET = 8'h0F; // Clock recovery reset value.
  localparam logic [3:0] SEL_LAST_EP = 4'h3; // Highest legal endpoint select code.
  // ----------------------------------------------------------------
  // FIFO memory layout, offsets inside the 1024-byte space
  // ----------------------------------------------------------------
  localparam int FIFO_BYTES = 1024; // Shared endpoint memory size.
  localparam logic [9:0] EP0_BASE = 10'h000; // Endpoint 0 region start.
  localparam logic [9:0] EP3_BASE = 10'h040; // Endpoint 3 region start.
  localparam logic [9:0] EP2_BASE = 10'h240; // Endpoint 2 region start.
  localparam logic [9:0] EP1_BASE = 10'h340; // Endpoint 1 region start.
  localparam logic [9:0] EP0_LEN = 10'h040; // Endpoint 0 region size.
  localparam logic [9:0] EP1_LEN = 10'h080; // Endpoint 1 region size.
  localparam logic [9:0] EP2_LEN = 10'h100; // Endpoint 2 region size.
  localparam logic [9:0] EP3_LEN = 10'h200; // Endpoint 3 region size.
  // ----------------------------------------------------------------
  // Clock recovery timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50; // System clock rate in MHz.
  localparam int FRAME_US = 1000; // Frame marker spacing in microseconds.
  localparam int FRAME_CYCLES_DEF = FRAME_US * CLK_MHZ; // Nominal cycles per frame.
  localparam int TOL_FS_CYCLES = 25; // Dead band in full speed mode.
  localparam int TOL_LS_CYCLES = 100; // Dead band in low speed mode.
  localparam logic [6:0] TRIM_RESET = 7'h40; // Mid-scale oscillator trim.
  localparam logic [6:0] STEP_NORMAL = 7'h04; // Trim step in normal calibration.
  localparam logic [6:0] STEP_SINGLE = 7'h01; // Trim step in single-step mode.
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One circular buffer: write offset, read offset and fill level.
  typedef struct packed {
    logic [9:0] wr;
    logic [9:0] rd;
    logic [9:0] cnt;
  } fifo_ptr_s;
  // A slice of the FIFO memory.
  typedef struct packed {
    logic [9:0] base;
    logic [9:0] len;
  } region_s;
  // Clock recovery control layout, bit 7 down to bit 0.
  typedef struct packed {
    logic en;
    logic single_step;
    logic low_speed;
    logic [4:0] spare;
  } clk_rec_s;
endpackage
`default_nettype wire

// >>> logic/usb_ep_fifo.sv
// Endpoint FIFO memory, endpoint pointer and clock recovery for a USB function.
// Assumes the packet engine and firmware strobes are on sys_clk_in already.
//
// How it works
// - Select field picks endpoint 0 to 3.
// - Pointer upper nibble reads zero, writes ignored.
// - Recovery trims oscillator from incoming frames.
// - Bit 7 enables recovery, resets to zero.
// - Bit 6 selects single-step trim calibration.
// - 1024 shared bytes serve endpoints 0-3.
// - Endpoints 1-3 are IN, OUT or split.
// - Split: upper half IN, lower half OUT.
// - Unsplit: one FIFO, direction bit chooses.
// - Double buffering halves packet size, endpoints 1-3.
// - Split halves double buffer independently.
// - Maximum packet sizes follow the size table.
// - Each port read pops, write pushes, one byte.
// - Split port reads OUT half, writes IN half.
// - FIFO ports sit at addresses 0x20-0x23.
// - Registers reached through address then data.
`default_nettype none
`timescale 1ns/10ps
module usb_ep_fifo #(
  parameter int FRAME_CYCLES = usb_fifo_pkg::FRAME_CYCLES_DEF
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic adr_wr_in,
  input wire logic [5:0] adr_in,
  input wire logic dat_wr_in,
  input wire logic dat_rd_in,
  input wire logic [7:0] dat_wdata_in,
  output logic [7:0] dat_rdata_out,
  output logic dat_rvalid_out,
  input wire logic [3:0] ep_split_in,
  input wire logic [3:0] ep_dir_in,
  input wire logic [3:0] dbl_in_in,
  input wire logic [3:0] dbl_out_in,
  input wire logic usb_rx_valid_in,
  input wire logic [1:0] usb_rx_ep_in,
  input wire logic [7:0] usb_rx_data_in,
  output logic usb_rx_ready_out,
  input wire logic usb_tx_pop_in,
  input wire logic [1:0] usb_tx_ep_in,
  output logic usb_tx_valid_out,
  output logic [7:0] usb_tx_data_out,
  output logic usb_tx_dvalid_out,
  output logic [9:0] sel_max_in_out,
  output logic [9:0] sel_max_out_out,
  input wire logic frame_mark_in,
  output logic rec_enable_out,
  output logic rec_single_step_out,
  output logic rec_low_speed_out,
  output logic [6:0] osc_trim_out
);
  import usb_fifo_pkg::*;

  // All assertions below run on the system clock and sleep while reset is applied.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Region of one buffer; set 1 is the IN half of a split endpoint.
  function automatic region_s region(input logic [1:0] e, input logic s, input logic sp);
    region_s r;
    logic [9:0] b;
    logic [9:0] l;
    unique case (e)
      2'd0: begin b = EP0_BASE; l = EP0_LEN; end
      2'd1: begin b = EP1_BASE; l = EP1_LEN; end
      2'd2: begin b = EP2_BASE; l = EP2_LEN; end
      2'd3: begin b = EP3_BASE; l = EP3_LEN; end
    endcase
    r.base = b;
    r.len = l;
    if (sp && e != 2'd0) begin
      r.len = l >> 1;
      r.base = s ? b + (l >> 1) : b;
    end
    return r;
  endfunction
  // Split applies to endpoints 1-3 only.
  function automatic logic split_of(input logic [1:0] e, input logic [3:0] sp);
    return (e != 2'd0) && sp[e];
  endfunction
  // Whether a transfer in the given direction is allowed on an endpoint.
  function automatic logic dir_ok(input logic [1:0] e, input logic want_in, input logic [3:0] sp,
                                  input logic [3:0] dir);
    return (e == 2'd0) || sp[e] || (dir[e] == want_in);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [FIFO_BYTES]; // Shared endpoint byte memory.
  fifo_ptr_s ptr_q [4][2]; // Buffer state per endpoint and set.
  fifo_ptr_s ptr_d [4][2];
  logic [5:0] adr_q, adr_d; // Indirect address field.
  logic [3:0] sel_q, sel_d; // Endpoint select field.
  clk_rec_s rec_q, rec_d; // Clock recovery control.
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [7:0] txd_q, txd_d;
  logic txv_q, txv_d;
  logic [9:0] max_in_q, max_in_d, max_out_q, max_out_d;
  logic [19:0] fcnt_q, fcnt_d; // Cycles since the last frame marker.
  logic seen_q, seen_d; // A frame marker has started a measurement.
  logic [6:0] trim_q, trim_d;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic fw_fifo, fw_sp, fw_push_en, fw_pop_en, rx_push_en, tx_pop_en, rx_set, tx_set;
  logic [1:0] fw_ep;
  logic [9:0] fw_wr_addr, fw_rd_addr, rx_wr_addr, tx_rd_addr;
  region_s fw_in_r, fw_out_r, rx_r, tx_r;
  fifo_ptr_s fw_in_p, fw_out_p, rx_p, tx_p;

  // Decodes the firmware FIFO port and both packet engine byte ports.
  always_comb begin
    fw_fifo = adr_q[5:2] == ADDR_FIFO0[5:2];
    fw_ep = adr_q[1:0];
    fw_sp = split_of(fw_ep, ep_split_in);
    // Writes load the IN half and reads unload the OUT half when split.
    fw_in_r = region(fw_ep, fw_sp, fw_sp);
    fw_in_p = ptr_q[fw_ep][fw_sp];
    fw_out_r = region(fw_ep, 1'b0, fw_sp);
    fw_out_p = ptr_q[fw_ep][0];
    fw_wr_addr = fw_in_r.base + fw_in_p.wr;
    fw_rd_addr = fw_out_r.base + fw_out_p.rd;
    fw_push_en = dat_wr_in && fw_fifo && dir_ok(fw_ep, 1'b1, ep_split_in, ep_dir_in) &&
                 (fw_in_p.cnt != fw_in_r.len);
    fw_pop_en = dat_rd_in && fw_fifo && dir_ok(fw_ep, 1'b0, ep_split_in, ep_dir_in) &&
                (fw_out_p.cnt != 10'd0);
    rx_set = 1'b0;
    rx_r = region(usb_rx_ep_in, rx_set, split_of(usb_rx_ep_in, ep_split_in));
    rx_p = ptr_q[usb_rx_ep_in][rx_set];
    rx_wr_addr = rx_r.base + rx_p.wr;
    // Firmware wins a same-buffer collision, which only endpoint 0 can see.
    usb_rx_ready_out = dir_ok(usb_rx_ep_in, 1'b0, ep_split_in, ep_dir_in) && (rx_p.cnt != rx_r.len) &&
                       !(fw_push_en && fw_ep == usb_rx_ep_in && !fw_sp);
    rx_push_en = usb_rx_valid_in && usb_rx_ready_out;
    tx_set = split_of(usb_tx_ep_in, ep_split_in);
    tx_r = region(usb_tx_ep_in, tx_set, tx_set);
    tx_p = ptr_q[usb_tx_ep_in][tx_set];
    tx_rd_addr = tx_r.base + tx_p.rd;
    usb_tx_valid_out = dir_ok(usb_tx_ep_in, 1'b1, ep_split_in, ep_dir_in) && (tx_p.cnt != 10'd0) &&
                       !(fw_pop_en && fw_ep == usb_tx_ep_in && !tx_set);
    tx_pop_en = usb_tx_pop_in && usb_tx_valid_out;
  end

  // ----------------------------------------------------------------
  // Buffer pointers
  // ----------------------------------------------------------------
  // Advances each buffer by its push and pop of this cycle, wrapping inside its region.
  always_comb begin
    for (int e = 0; e < 4; e++) begin
      for (int s = 0; s < 2; s++) begin
        region_s r;
        logic push, pop;
        r = region(2'(e), 1'(s), split_of(2'(e), ep_split_in));
        push = (fw_push_en && fw_ep == 2'(e) && fw_sp == 1'(s)) ||
               (rx_push_en && usb_rx_ep_in == 2'(e) && s == 0);
        pop = (fw_pop_en && fw_ep == 2'(e) && s == 0) ||
              (tx_pop_en && usb_tx_ep_in == 2'(e) && tx_set == 1'(s));
        ptr_d[e][s] = ptr_q[e][s];
        if (push) begin
          ptr_d[e][s].wr = (ptr_q[e][s].wr == r.len - 10'd1) ? 10'd0 : ptr_q[e][s].wr + 10'd1;
        end
        if (pop) begin
          ptr_d[e][s].rd = (ptr_q[e][s].rd == r.len - 10'd1) ? 10'd0 : ptr_q[e][s].rd + 10'd1;
        end
        ptr_d[e][s].cnt = ptr_q[e][s].cnt + {9'd0, push} - {9'd0, pop};
      end
    end
  end

  // Registers the buffer state.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int e = 0; e < 4; e++) begin
        for (int s = 0; s < 2; s++) begin
          ptr_q[e][s] <= '0;
        end
      end
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Stores pushed bytes; memory contents need no reset.
  always_ff @(posedge sys_clk_in) begin
    if (fw_push_en) begin
      mem[fw_wr_addr] <= dat_wdata_in;
    end
    if (rx_push_en) begin
      mem[rx_wr_addr] <= usb_rx_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Registers, read data and packet sizes
  // ----------------------------------------------------------------
  // Computes register updates, read data and the selected endpoint's packet sizes.
  always_comb begin
    logic sp;
    region_s rg;
    sp = 1'b0;
    rg = '0;
    adr_d = adr_wr_in ? adr_in : adr_q;
    sel_d = sel_q;
    rec_d = rec_q;
    rdata_d = rdata_q;
    rvalid_d = dat_rd_in;
    txv_d = tx_pop_en;
    txd_d = tx_pop_en ? mem[tx_rd_addr] : txd_q;
    if (dat_wr_in && adr_q == ADDR_EP_PTR) begin
      sel_d = dat_wdata_in[3:0];
    end
    if (dat_wr_in && adr_q == ADDR_CLK_REC) begin
      rec_d = clk_rec_s'(dat_wdata_in);
    end
    if (dat_rd_in) begin
      if (adr_q == ADDR_EP_PTR) begin
        rdata_d = {4'h0, sel_q};
      end else if (adr_q == ADDR_CLK_REC) begin
        rdata_d = rec_q;
      end else if (fw_pop_en) begin
        rdata_d = mem[fw_rd_addr];
      end else begin
        rdata_d = 8'h00;
      end
    end
    max_in_d = 10'd0;
    max_out_d = 10'd0;
    if (sel_q <= SEL_LAST_EP) begin
      sp = split_of(sel_q[1:0], ep_split_in);
      rg = region(sel_q[1:0], sp, sp);
      max_in_d = rg.len;
      rg = region(sel_q[1:0], 1'b0, sp);
      max_out_d = rg.len;
      if (sel_q != 4'h0 && dbl_in_in[sel_q[1:0]]) begin
        max_in_d = max_in_d >> 1;
      end
      if (sel_q != 4'h0 && (sp ? dbl_out_in[sel_q[1:0]] : dbl_in_in[sel_q[1:0]])) begin
        max_out_d = max_out_d >> 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock recovery
  // ----------------------------------------------------------------
  // Measures cycles between frame markers and nudges the oscillator trim.
  always_comb begin
    logic [6:0] step;
    int tol;
    step = rec_q.single_step ? STEP_SINGLE : STEP_NORMAL;
    tol = rec_q.low_speed ? TOL_LS_CYCLES : TOL_FS_CYCLES;
    trim_d = trim_q;
    seen_d = seen_q && rec_q.en;
    fcnt_d = (fcnt_q == 20'hFFFFF) ? fcnt_q : fcnt_q + 20'd1;
    if (frame_mark_in) begin
      fcnt_d = 20'd0;
      seen_d = rec_q.en;
      if (rec_q.en && seen_q) begin
        if (int'(fcnt_q) > FRAME_CYCLES + tol) begin
          trim_d = (trim_q < step) ? 7'h00 : trim_q - step;
        end else if (int'(fcnt_q) < FRAME_CYCLES - tol) begin
          trim_d = (trim_q > 7'h7F - step) ? 7'h7F : trim_q + step;
        end
      end
    end
  end

  // Registers control, read data and recovery state.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adr_q <= 6'h00;
      sel_q <= EP_PTR_RESET[3:0];
      rec_q <= clk_rec_s'(CLK_REC_RESET);
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      txd_q <= 8'h00;
      txv_q <= 1'b0;
      max_in_q <= 10'd0;
      max_out_q <= 10'd0;
      fcnt_q <= 20'd0;
      seen_q <= 1'b0;
      trim_q <= TRIM_RESET;
    end else begin
      adr_q <= adr_d;
      sel_q <= sel_d;
      rec_q <= rec_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      txd_q <= txd_d;
      txv_q <= txv_d;
      max_in_q <= max_in_d;
      max_out_q <= max_out_d;
      fcnt_q <= fcnt_d;
      seen_q <= seen_d;
      trim_q <= trim_d;
    end
  end

  // Output drive.
  assign dat_rdata_out = rdata_q;
  assign dat_rvalid_out = rvalid_q;
  assign usb_tx_data_out = txd_q;
  assign usb_tx_dvalid_out = txv_q;
  assign sel_max_in_out = max_in_q;
  assign sel_max_out_out = max_out_q;
  assign rec_enable_out = rec_q.en;
  assign rec_single_step_out = rec_q.single_step;
  assign rec_low_speed_out = rec_q.low_speed;
  assign osc_trim_out = trim_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ptr_upper_zero: assert property (dat_rd_in && adr_q == ADDR_EP_PTR |=> dat_rdata_out[7:4] == 4'h0)
    else $error("pointer upper bits not zero");
  a_read_answer: assert property (dat_rd_in |=> dat_rvalid_out ##1 !dat_rvalid_out || $past(dat_rd_in))
    else $error("read answer not one cycle later");
  a_rec_enable: assert property (dat_wr_in && adr_q == ADDR_CLK_REC |=>
                                 rec_enable_out == $past(dat_wdata_in[7]))
    else $error("recovery enable not updated");
  a_reserved_sel: assert property (sel_q > SEL_LAST_EP |=>
                                   sel_max_in_out == 10'd0 && sel_max_out_out == 10'd0)
    else $error("reserved select gave packet size");
  a_ep3_max: assert property (sel_q == 4'h3 && !ep_split_in[3] && !dbl_in_in[3] |=>
                              sel_max_in_out == 10'd512)
    else $error("endpoint 3 size wrong");
  a_split_in_half: assert property (fw_push_en && fw_ep == 2'd3 && fw_sp |->
                                    fw_wr_addr >= EP3_BASE + 10'h100)
    else $error("split write outside IN half");
  a_split_out_half: assert property (rx_push_en && usb_rx_ep_in == 2'd3 && ep_split_in[3] |->
                                     rx_wr_addr < EP3_BASE + 10'h100)
    else $error("split receive outside OUT half");
  a_dir_gate: assert property (dat_wr_in && fw_fifo && fw_ep != 2'd0 &&
                               !ep_split_in[fw_ep] && !ep_dir_in[fw_ep] |-> !fw_push_en)
    else $error("write accepted on OUT endpoint");
  a_pop_one: assert property (fw_pop_en && fw_ep == 2'd1 && !(rx_push_en && usb_rx_ep_in == 2'd1) |=>
                              ptr_q[1][0].cnt == $past(ptr_q[1][0].cnt) - 10'd1)
    else $error("pop did not remove one byte");
  a_trim_single: assert property (rec_q.single_step && frame_mark_in |=>
                                  (trim_q - $past(trim_q) <= 7'd1) || ($past(trim_q) - trim_q <= 7'd1))
    else $error("single step moved trim too far");
endmodule
`default_nettype wire

// >>> sim/usb_host_model.sv
// Packet engine model: offers OUT bytes, pops IN bytes and sends frame markers.
// Assumes the bench calls its tasks from one process, on the system clock.
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  input wire logic sys_clk_in,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  input wire logic tx_dvalid_in,
  input wire logic [7:0] tx_data_in,
  output logic rx_valid_out,
  output logic [1:0] rx_ep_out,
  output logic [7:0] rx_data_out,
  output logic tx_pop_out,
  output logic [1:0] tx_ep_out,
  output logic frame_mark_out
);
  // Everything idle at time zero.
  initial begin
    rx_valid_out = 1'b0;
    rx_ep_out = 2'h0;
    rx_data_out = 8'h00;
    tx_pop_out = 1'b0;
    tx_ep_out = 2'h0;
    frame_mark_out = 1'b0;
  end
  // Offers one byte and holds it until taken or the bound runs out.
  task automatic send(input logic [1:0] ep, input logic [7:0] data, output bit ok);
    ok = 1'b0;
    @(posedge sys_clk_in);
    #1;
    rx_valid_out = 1'b1;
    rx_ep_out = ep;
    rx_data_out = data;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge sys_clk_in);
      ok = rx_ready_in;
    end
    #1;
    rx_valid_out = 1'b0;
    rx_data_out = ~data; // A released line must not show the stale byte.
  endtask
  // Pops one byte; the byte is taken in the cycle after acceptance.
  task automatic pop(input logic [1:0] ep, output logic [7:0] data, output bit ok);
    ok = 1'b0;
    @(posedge sys_clk_in);
    #1;
    tx_pop_out = 1'b1;
    tx_ep_out = ep;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge sys_clk_in);
      ok = tx_valid_in;
    end
    #1;
    tx_pop_out = 1'b0;
    data = (tx_dvalid_in === 1'b1) ? tx_data_in : 8'hXX;
  endtask
  // One frame marker pulse of a single cycle; the 6 or 48 MHz bit clock stays out here.
  task automatic mark();
    @(posedge sys_clk_in);
    #1;
    frame_mark_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    frame_mark_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/usb_ep_fifo_tb.sv
// Self-checking bench for the endpoint FIFO, pointer and clock recovery block.
// Assumes the packet engine model sits on the USB side; firmware is modelled here.
`timescale 1ns/10ps
`default_nettype none
module usb_ep_fifo_tb;
  import usb_fifo_pkg::*;
  localparam int FRAME_SIM = 200; // Short frame so recovery runs quickly.
  logic sys_clk_in, nrst_in, adr_wr, dat_wr, dat_rd, rvalid, rx_valid, rx_ready, tx_pop, tx_valid;
  logic tx_dvalid, frame, rec_en, rec_ss, rec_ls;
  logic [5:0] adr;
  logic [7:0] wdata, rdata, rx_data, tx_data, v, r;
  logic [3:0] split, dir, dbl_in, dbl_out;
  logic [1:0] rx_ep, tx_ep;
  logic [9:0] max_in, max_out;
  logic [6:0] trim;
  logic [7:0] in_b [4];
  logic [7:0] out_b [4];
  int error_cnt = 0;
  int comparisons = 0;
  bit ok;
  usb_ep_fifo #(.FRAME_CYCLES(FRAME_SIM)) i_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .adr_wr_in(adr_wr), .adr_in(adr), .dat_wr_in(dat_wr), .dat_rd_in(dat_rd), .dat_wdata_in(wdata),
    .dat_rdata_out(rdata), .dat_rvalid_out(rvalid), .ep_split_in(split), .ep_dir_in(dir),
    .dbl_in_in(dbl_in), .dbl_out_in(dbl_out), .usb_rx_valid_in(rx_valid), .usb_rx_ep_in(rx_ep),
    .usb_rx_data_in(rx_data), .usb_rx_ready_out(rx_ready), .usb_tx_pop_in(tx_pop), .usb_tx_ep_in(tx_ep),
    .usb_tx_valid_out(tx_valid), .usb_tx_data_out(tx_data), .usb_tx_dvalid_out(tx_dvalid),
    .sel_max_in_out(max_in), .sel_max_out_out(max_out), .frame_mark_in(frame), .rec_enable_out(rec_en),
    .rec_single_step_out(rec_ss), .rec_low_speed_out(rec_ls), .osc_trim_out(trim));
  usb_host_model i_host (.sys_clk_in(sys_clk_in), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid),
    .tx_dvalid_in(tx_dvalid), .tx_data_in(tx_data), .rx_valid_out(rx_valid), .rx_ep_out(rx_ep),
    .rx_data_out(rx_data), .tx_pop_out(tx_pop), .tx_ep_out(tx_ep), .frame_mark_out(frame));
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Loads the address, then strobes the data register one cycle later.
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    adr_wr = 1'b1;
    adr = a;
    @(posedge sys_clk_in);
    #1;
    adr_wr = 1'b0;
    dat_wr = 1'b1;
    wdata = d;
    @(posedge sys_clk_in);
    #1;
    dat_wr = 1'b0;
  endtask
  // Read answer arrives exactly one cycle after the read strobe.
  task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    adr_wr = 1'b1;
    adr = a;
    @(posedge sys_clk_in);
    #1;
    adr_wr = 1'b0;
    dat_rd = 1'b1;
    @(posedge sys_clk_in);
    #1;
    dat_rd = 1'b0;
    check(10'(rvalid), 10'h001, "read answer");
    if (rvalid !== 1'b1) wrap_up();
    d = rdata;
  endtask
  // Largest packet for the selected endpoint, zero for reserved codes.
  function automatic logic [9:0] exp_max(int ep, bit is_in);
    logic [9:0] len;
    if (ep > 3) return 10'h000;
    if (ep == 0) return 10'h040;
    len = 10'(128 << (ep - 1));
    if (!split[ep]) return len >> dbl_in[ep];
    return is_in ? (len >> 1) >> dbl_in[ep] : (len >> 1) >> dbl_out[ep];
  endfunction
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (30000) @(posedge sys_clk_in);
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h1463));
    {nrst_in, adr_wr, dat_wr, dat_rd, adr, wdata} = '0;
    {split, dir, dbl_in, dbl_out} = '0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    nrst_in = 1'b1;
    reg_rd(ADDR_EP_PTR, r);
    check(10'(r), 10'h000, "pointer reset");
    reg_rd(ADDR_CLK_REC, r);
    check(10'(r), 10'h00F, "recovery reset");
    check(10'(rec_en), 10'h000, "enable reset");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = {4'($urandom), 4'(i)};
      {split, dbl_in, dbl_out} = 12'($urandom);
      reg_wr(ADDR_EP_PTR, v);
      reg_rd(ADDR_EP_PTR, r);
      check(10'(r), {6'h00, v[3:0]}, "pointer readback");
      check(max_in, exp_max(i, 1'b1), "max in");
      check(max_out, exp_max(i, 1'b0), "max out");
    end
    // Corner: endpoint 3 unsplit and single buffered, upper nibble written as ones.
    {split, dbl_in} = 8'h00;
    reg_wr(ADDR_EP_PTR, 8'hF3);
    reg_rd(ADDR_EP_PTR, r);
    check(10'(r), 10'h003, "pointer nibble");
    check(max_in, 10'h200, "ep3 max");
    $display("test select done");
    {split, dbl_in, dbl_out} = {4'hE, 8'h00};
    for (int e = 1; e < 4; e++) begin
      for (int k = 0; k < 4; k++) begin
        in_b[k] = 8'($urandom);
        out_b[k] = 8'($urandom);
        reg_wr(ADDR_FIFO0 + 6'(e), in_b[k]);
      end
      for (int k = 0; k < 4; k++) begin
        i_host.send(2'(e), out_b[k], ok);
        check(10'(ok), 10'h001, "rx taken");
        if (!ok) wrap_up();
      end
      for (int k = 0; k < 4; k++) begin
        reg_rd(ADDR_FIFO0 + 6'(e), r);
        check(10'(r), 10'(out_b[k]), "port read");
      end
      reg_rd(ADDR_FIFO0 + 6'(e), r);
      check(10'(r), 10'h000, "empty read");
      for (int k = 0; k < 4; k++) begin
        i_host.pop(2'(e), r, ok);
        check(10'(r), 10'(in_b[k]), "tx byte");
        if (!ok) wrap_up();
      end
      i_host.pop(2'(e), r, ok);
      check(10'(ok), 10'h000, "tx empty");
    end
    $display("test split done");
    split = 4'hA;
    dir = 4'h4;
    v = 8'($urandom);
    i_host.send(2'd2, v, ok);
    check(10'(ok), 10'h000, "rx wrong dir");
    reg_wr(ADDR_FIFO0 + 6'd2, v);
    i_host.pop(2'd2, r, ok);
    check(10'(r), 10'(v), "unsplit in");
    dir = 4'h0;
    reg_wr(ADDR_FIFO0 + 6'd2, ~v);
    i_host.pop(2'd2, r, ok);
    check(10'(ok), 10'h000, "tx wrong dir");
    i_host.send(2'd2, v, ok);
    reg_rd(ADDR_FIFO0 + 6'd2, r);
    check(10'(r), 10'(v), "unsplit out");
    // Endpoint 0 carries both directions in one shared buffer.
    reg_wr(ADDR_FIFO0, v);
    i_host.pop(2'd0, r, ok);
    check(10'(r), 10'(v), "ep0 in");
    v = 8'($urandom);
    i_host.send(2'd0, v, ok);
    reg_rd(ADDR_FIFO0, r);
    check(10'(r), 10'(v), "ep0 out");
    reg_wr(6'h3F, 8'hA5);
    reg_rd(6'h3F, r);
    check(10'(r), 10'h000, "unmapped");
    $display("test unsplit done");
    reg_wr(ADDR_CLK_REC, 8'h8F);
    check(10'(rec_en), 10'h001, "enable bit");
    i_host.mark();
    repeat (300) @(posedge sys_clk_in);
    i_host.mark();
    check(10'(trim), 10'(TRIM_RESET - STEP_NORMAL), "slow frame");
    reg_wr(ADDR_CLK_REC, 8'h0F);
    reg_wr(ADDR_CLK_REC, 8'hCF);
    reg_rd(ADDR_CLK_REC, r);
    check(10'(r), 10'h0CF, "recovery readback");
    check(10'(rec_ss), 10'h001, "single step bit");
    i_host.mark();
    repeat (100) @(posedge sys_clk_in);
    i_host.mark();
    check(10'(trim), 10'(TRIM_RESET - STEP_NORMAL + STEP_SINGLE), "single step");
    reg_wr(ADDR_CLK_REC, 8'h0F);
    reg_wr(ADDR_CLK_REC, 8'hAF);
    check(10'(rec_ls), 10'h001, "low speed bit");
    check(10'(rec_ss), 10'h000, "normal step bit");
    i_host.mark();
    repeat (250) @(posedge sys_clk_in);
    i_host.mark();
    check(10'(trim), 10'(TRIM_RESET - STEP_NORMAL + STEP_SINGLE), "low speed band");
    $display("test recovery done");
    wrap_up();
  end
endmodule
`default_nettype wire
